// ==== pkg/csad_params.svh ====
// Timing counts, field limits and reset values of the clock source and distribution block.
// Function
// - Main oscillator output frequency is selectable among 3, 6, 12, 24, 48, 62 MHz.
// - Doubler emits twice its input rate; input is main, crystal or interconnect.
// - PLL input and feedback dividers give 4032 ratios for 24 to 67 MHz.
// - PLL sets a readable lock bit within 250 us of start.
// - PLL input is main oscillator, fast crystal or interconnect clock.
// - PLL output usable while locking; lock event routable to interconnect for interrupts.
// - Low-speed oscillator provides 1 kHz, 33 kHz and 100 kHz clocks.
// - Central tick counter is a free-running 13-bit counter on the 1 kHz clock.
// - Central tick counter runs always, except hibernate and debug halt.
// - Central tick counter gives periodic wake events; firmware can clear it.
// - Fast tick counter is 5-bit at 100 kHz, restarting at programmable terminal count.
// - Fast tick counter interrupts at terminal count only when enabled.
// - The 33 kHz clock is the 100 kHz clock divided by three.
// - Watch crystal clocks the sleep timer and yields a once-per-second event.
// - Eight extra interconnect clocks feed the eight digital dividers directly.
// - Seven sources enter distribution; master selection picks one of them.
// - A 16-bit divider makes bus clock from master; bus feeds CPU divider.
// - Eight programmable 16-bit dividers make digital clocks from any source.
// - Four 16-bit analog dividers have skew control against digital edges.
// - Each divider: 8-input mux, divide by 2 or more, ~50% duty, resync, deglitch.
// - Digital divider outputs return through interconnect, allowing 32-bit chained division.
// - USB clock is 48 MHz from interconnect or doubled 24 MHz source.
`ifndef CSAD_PARAMS_SVH
`define CSAD_PARAMS_SVH
`define CSAD_CLK_HZ      20000000
`define CSAD_CLK_MHZ     20
`define CSAD_LPF_HZ      100000
`define CSAD_LPF_DIV     (`CSAD_CLK_HZ / `CSAD_LPF_HZ)
`define CSAD_SLOW_HZ     1000
`define CSAD_SLOW_DIV    (`CSAD_LPF_HZ / `CSAD_SLOW_HZ)
`define CSAD_THIRD_DIV   3
`define CSAD_PLL_LOCK_US 250
`define CSAD_PLL_LOCK_CYC (`CSAD_PLL_LOCK_US * `CSAD_CLK_MHZ)
`define CSAD_WATCH_LAST  15'h7FFF
`define CSAD_DIV_MIN     16'h0002
`define CSAD_IMO_MAXCODE 3'h5
`define CSAD_IMO_RST     3'h0
`define CSAD_CREDIT_CAP  12'h800
`define CSAD_NDIV        14
`define CSAD_DIG_BASE    2
`define CSAD_ANA_BASE    10
`endif

// ==== pkg/csad_pkg.sv ====
// Types shared by the clock source and distribution modules.
package csad_pkg;
	typedef enum logic [2:0] {
		SRC_MAIN  = 3'h0,
		SRC_XTAL  = 3'h1,
		SRC_LPF   = 3'h2,
		SRC_WATCH = 3'h3,
		SRC_PLL   = 3'h4,
		SRC_DSI   = 3'h5,
		SRC_DBL   = 3'h6,
		SRC_AUX   = 3'h7
	} csad_src_e;
	typedef enum logic [2:0] {
		PLL_OFF     = 3'h1,
		PLL_LOCKING = 3'h2,
		PLL_LOCKED  = 3'h4
	} csad_pll_e;
	typedef logic [15:0] csad_div_t;
endpackage : csad_pkg

// ==== pkg/csad_div_if.sv ====
// Connection between the distribution logic and one clock divider.
`timescale 1ns/1ns
interface csad_div_if;
	logic [7:0]         srcTick;
	logic [2:0]         srcSel;
	csad_pkg::csad_div_t divVal;
	logic [3:0]         skew;
	logic               resyncEn;
	logic               masterTick;
	logic               clkOut;
	logic               tickOut;
	modport div (input srcTick, srcSel, divVal, skew, resyncEn, masterTick, output clkOut, tickOut);
	modport ctl (output srcTick, srcSel, divVal, skew, resyncEn, masterTick, input clkOut, tickOut);
endinterface : csad_div_if

// ==== hdl/csad_divider.sv ====
// One 16-bit clock divider with source mux, skew delay, master resync and deglitch.
`timescale 1ns/1ns
`include "csad_params.svh"
module csad_divider (
	input wire logic clock,
	input wire logic rstn,
	csad_div_if.div  dv
);
	logic [15:0] cnt_q;
	logic [2:0]  sel_q;
	logic        phase_q;
	logic        lvl_q;
	logic [3:0]  skewCnt_q;
	logic        clkOut_q;
	logic        tickOut_q;
	logic [15:0] ratio;
	logic [15:0] cntNext;
	logic        upd;

	// Division below two is forced to two; the high phase covers the first half count.
	assign ratio   = (dv.divVal < `CSAD_DIV_MIN) ? `CSAD_DIV_MIN : dv.divVal;
	assign cntNext = (cnt_q == ratio - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
	assign upd     = !dv.resyncEn || dv.masterTick;

	// Source switch restarts the count with the output low so no runt pulse escapes.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_q   <= 16'h0000;
			sel_q   <= 3'h0;
			phase_q <= 1'b0;
		end else if (dv.srcSel != sel_q) begin
			sel_q   <= dv.srcSel;
			cnt_q   <= 16'h0000;
			phase_q <= 1'b0;
		end else if (dv.srcTick[sel_q]) begin
			cnt_q   <= cntNext;
			phase_q <= (cntNext < (ratio >> 1));
		end
	end

	// Each phase change waits skew cycles before reaching the output.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lvl_q     <= 1'b0;
			skewCnt_q <= 4'h0;
		end else if (lvl_q != phase_q) begin
			if (skewCnt_q == dv.skew) begin
				lvl_q     <= phase_q;
				skewCnt_q <= 4'h0;
			end else begin
				skewCnt_q <= skewCnt_q + 4'h1;
			end
		end else begin
			skewCnt_q <= 4'h0;
		end
	end

	// The output level moves only on a master tick when resync is on.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			clkOut_q  <= 1'b0;
			tickOut_q <= 1'b0;
		end else begin
			if (upd) begin
				clkOut_q <= lvl_q;
			end
			tickOut_q <= upd && lvl_q && !clkOut_q;
		end
	end

	assign dv.clkOut  = clkOut_q;
	assign dv.tickOut = tickOut_q;
endmodule : csad_divider

// ==== hdl/csad_lowpower.sv ====
// Low-speed oscillator clocks with the central and fast tick counters.
`timescale 1ns/1ns
`include "csad_params.svh"
module csad_lowpower (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        hibernate,
	input  wire logic        debugHalt,
	input  wire logic        ctcClear,
	input  wire logic [3:0]  ctcTap,
	input  wire logic        ftcIrqEn,
	input  wire logic [4:0]  ftcTerminal,
	output logic             lpfTick,
	output logic             slowTick,
	output logic             thirdTick,
	output logic [12:0]      ctcCount,
	output logic             ctcEvent,
	output logic [4:0]       ftcCount,
	output logic             ftcIrq
);
	logic [7:0]  lpfDiv_q;
	logic [6:0]  slowDiv_q;
	logic [1:0]  thirdDiv_q;
	logic [12:0] tapMask;
	logic        ctcRun;

	assign tapMask = 13'((14'h0002 << ctcTap) - 14'h0001);
	assign ctcRun  = slowTick && !hibernate && !debugHalt;

	// The 100 kHz, 1 kHz and 33 kHz enables, each one cycle wide.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lpfDiv_q   <= 8'h00;
			slowDiv_q  <= 7'h00;
			thirdDiv_q <= 2'h0;
			lpfTick    <= 1'b0;
			slowTick   <= 1'b0;
			thirdTick  <= 1'b0;
		end else begin
			lpfTick   <= (lpfDiv_q == 8'(`CSAD_LPF_DIV - 1));
			lpfDiv_q  <= (lpfDiv_q == 8'(`CSAD_LPF_DIV - 1)) ? 8'h00 : lpfDiv_q + 8'h01;
			slowTick  <= 1'b0;
			thirdTick <= 1'b0;
			if (lpfTick) begin
				slowTick   <= (slowDiv_q == 7'(`CSAD_SLOW_DIV - 1));
				slowDiv_q  <= (slowDiv_q == 7'(`CSAD_SLOW_DIV - 1)) ? 7'h00 : slowDiv_q + 7'h01;
				thirdTick  <= (thirdDiv_q == 2'(`CSAD_THIRD_DIV - 1));
				thirdDiv_q <= (thirdDiv_q == 2'(`CSAD_THIRD_DIV - 1)) ? 2'h0 : thirdDiv_q + 2'h1;
			end
		end
	end

	// Central counter: clear wins, halts in hibernate or debug, wraps freely.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctcCount <= 13'h0000;
			ctcEvent <= 1'b0;
		end else begin
			ctcEvent <= ctcRun && ((ctcCount & tapMask) == tapMask);
			if (ctcClear) begin
				ctcCount <= 13'h0000;
			end else if (ctcRun) begin
				ctcCount <= ctcCount + 13'h0001;
			end
		end
	end

	// Fast counter restarts at its terminal count and flags it when enabled.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ftcCount <= 5'h00;
			ftcIrq   <= 1'b0;
		end else begin
			ftcIrq <= 1'b0;
			if (lpfTick) begin
				if (ftcCount >= ftcTerminal) begin
					ftcCount <= 5'h00;
					ftcIrq   <= ftcIrqEn;
				end else begin
					ftcCount <= ftcCount + 5'h01;
				end
			end
		end
	end
endmodule : csad_lowpower

// ==== hdl/csad_top.sv ====
// Clock sources, PLL, doubler and divider tree of the clock control block.
`timescale 1ns/1ns
`include "csad_params.svh"
module csad_top #(
	parameter int unsigned PLL_LOCK_CYC = `CSAD_PLL_LOCK_CYC
) (
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              mainOscTick,
	input  wire logic [2:0]        mainOscCode,
	input  wire logic              fastXtalTick,
	input  wire logic              watchXtalTick,
	input  wire logic              dsiTick,
	input  wire logic [7:0]        dsiDigTick,
	input  wire logic [1:0]        dblSrcSel,
	input  wire logic              pllEnable,
	input  wire logic [1:0]        pllSrcSel,
	input  wire logic [5:0]        pllInDiv,
	input  wire logic [5:0]        pllFbDiv,
	input  wire logic              usbSrcSel,
	input  wire logic              hibernate,
	input  wire logic              debugHalt,
	input  wire logic              ctcClear,
	input  wire logic [3:0]        ctcTap,
	input  wire logic              ftcIrqEn,
	input  wire logic [4:0]        ftcTerminal,
	input  wire logic [2:0]        masterSel,
	input  wire logic [15:0]       busDiv,
	input  wire logic [15:0]       cpuDiv,
	input  wire logic [7:0][2:0]   digSel,
	input  wire logic [7:0][15:0]  digDiv,
	input  wire logic [7:0]        digResync,
	input  wire logic [3:0][2:0]   anaSel,
	input  wire logic [3:0][15:0]  anaDiv,
	input  wire logic [3:0][3:0]   anaSkew,
	output logic [2:0]             mainOscFreqSel,
	output logic                   pllLocked,
	output logic                   pllLockPulse,
	output logic                   pllTick,
	output logic                   dblTick,
	output logic                   lpfTick,
	output logic                   slowTick,
	output logic                   thirdTick,
	output logic [12:0]            ctcCount,
	output logic                   ctcEvent,
	output logic [4:0]             ftcCount,
	output logic                   ftcIrq,
	output logic                   sleepTick,
	output logic                   rtcSecond,
	output logic                   masterTick,
	output logic                   busClk,
	output logic                   cpuClk,
	output logic [7:0]             digClk,
	output logic [3:0]             anaClk,
	output logic                   usbTick
);
	// Picks one of the seven sources; the unused code falls back to the main oscillator.
	function automatic logic pickSrc(input logic [6:0] vec, input logic [2:0] sel);
		pickSrc = (sel == csad_pkg::SRC_AUX) ? vec[csad_pkg::SRC_MAIN] : vec[sel];
	endfunction : pickSrc

	logic [6:0]          srcVec;
	logic [6:0]          lowSrcVec;
	logic [2:0]          mainOscFreqSel_q;
	logic                masterTick_q;
	logic                usbTick_q;
	logic                sleepTick_q;
	logic                rtcSecond_q;
	logic [14:0]         watchCnt_q;
	logic                dblIn;
	logic [15:0]         dblCnt_q;
	logic [15:0]         dblPeriod_q;
	logic                dblTick_q;
	logic                pllIn;
	csad_pkg::csad_pll_e pllState_q;
	logic [15:0]         lockCnt_q;
	logic [13:0]         pllCfg_q;
	logic                pllEnable_q;
	logic                pllLockPulse_q;
	logic [11:0]         credit_q;
	logic [11:0]         creditAdd;
	logic [11:0]         inFactor;
	logic [11:0]         fbFactor;
	logic                pllTick_q;
	logic                lpfTickInt;

	// The seven distribution sources in their mux order.
	always_comb begin
		srcVec                       = 7'h00;
		srcVec[csad_pkg::SRC_MAIN]  = mainOscTick;
		srcVec[csad_pkg::SRC_XTAL]  = fastXtalTick;
		srcVec[csad_pkg::SRC_LPF]   = lpfTickInt;
		srcVec[csad_pkg::SRC_WATCH] = watchXtalTick;
		srcVec[csad_pkg::SRC_PLL]   = pllTick_q;
		srcVec[csad_pkg::SRC_DSI]   = dsiTick;
		srcVec[csad_pkg::SRC_DBL]   = dblTick_q;
	end

	// Doubler and PLL only see main oscillator, fast crystal or interconnect.
	assign lowSrcVec = {3'h0, mainOscTick, dsiTick, fastXtalTick, mainOscTick};
	assign dblIn     = pickSrc(lowSrcVec, {1'b0, dblSrcSel});
	assign pllIn     = pickSrc(lowSrcVec, {1'b0, pllSrcSel});

	// Main oscillator range code; codes above the top range are ignored.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mainOscFreqSel_q <= `CSAD_IMO_RST;
		end else if (mainOscCode <= `CSAD_IMO_MAXCODE) begin
			mainOscFreqSel_q <= mainOscCode;
		end
	end

	// Master tick follows the selected source one cycle later.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			masterTick_q <= 1'b0;
		end else begin
			masterTick_q <= pickSrc(srcVec, masterSel);
		end
	end

	// Doubler measures the input period and adds a second tick halfway through it.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dblCnt_q    <= 16'h0000;
			dblPeriod_q <= 16'h0000;
			dblTick_q   <= 1'b0;
		end else if (dblIn) begin
			dblPeriod_q <= dblCnt_q + 16'h0001;
			dblCnt_q    <= 16'h0000;
			dblTick_q   <= 1'b1;
		end else begin
			if (dblCnt_q != 16'hFFFF) begin
				dblCnt_q <= dblCnt_q + 16'h0001;
			end
			dblTick_q <= (dblPeriod_q > 16'h0001) && (dblCnt_q + 16'h0001 == (dblPeriod_q >> 1));
		end
	end

	// PLL lock sequence; a change of source or divider restarts the lock wait.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pllState_q     <= csad_pkg::PLL_OFF;
			lockCnt_q      <= 16'h0000;
			pllCfg_q       <= 14'h0000;
			pllEnable_q    <= 1'b0;
			pllLockPulse_q <= 1'b0;
		end else begin
			pllEnable_q    <= pllEnable;
			pllCfg_q       <= {pllSrcSel, pllInDiv, pllFbDiv};
			pllLockPulse_q <= 1'b0;
			case (pllState_q)
				csad_pkg::PLL_OFF: begin
					lockCnt_q <= 16'h0000;
					if (pllEnable && !pllEnable_q) begin
						pllState_q <= csad_pkg::PLL_LOCKING;
					end
				end
				csad_pkg::PLL_LOCKING: begin
					if (!pllEnable) begin
						pllState_q <= csad_pkg::PLL_OFF;
					end else if (pllCfg_q != {pllSrcSel, pllInDiv, pllFbDiv}) begin
						lockCnt_q <= 16'h0000;
					end else if (lockCnt_q == 16'(PLL_LOCK_CYC - 1)) begin
						pllState_q     <= csad_pkg::PLL_LOCKED;
						pllLockPulse_q <= 1'b1;
					end else begin
						lockCnt_q <= lockCnt_q + 16'h0001;
					end
				end
				csad_pkg::PLL_LOCKED: begin
					lockCnt_q <= 16'h0000;
					if (!pllEnable) begin
						pllState_q <= csad_pkg::PLL_OFF;
					end else if (pllCfg_q != {pllSrcSel, pllInDiv, pllFbDiv}) begin
						pllState_q <= csad_pkg::PLL_LOCKING;
					end
				end
				default: begin
					pllState_q <= csad_pkg::PLL_OFF;
				end
			endcase
		end
	end

	// Input factor 1..64 and feedback factor 1..63 give the ratio set.
	assign inFactor  = {5'h00, 7'({1'b0, pllInDiv} + 7'h01)};
	assign fbFactor  = (pllFbDiv == 6'h00) ? 12'h001 : {6'h00, pllFbDiv};
	assign creditAdd = (pllIn && credit_q < `CSAD_CREDIT_CAP) ? fbFactor : 12'h000;

	// Output ticks average input rate times feedback over input factor.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			credit_q  <= 12'h000;
			pllTick_q <= 1'b0;
		end else if (pllState_q == csad_pkg::PLL_OFF) begin
			credit_q  <= 12'h000;
			pllTick_q <= 1'b0;
		end else if (credit_q + creditAdd >= inFactor) begin
			credit_q  <= credit_q + creditAdd - inFactor;
			pllTick_q <= 1'b1;
		end else begin
			credit_q  <= credit_q + creditAdd;
			pllTick_q <= 1'b0;
		end
	end

	// Watch crystal feeds the sleep timer and marks each full second.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			watchCnt_q  <= 15'h0000;
			sleepTick_q <= 1'b0;
			rtcSecond_q <= 1'b0;
		end else begin
			sleepTick_q <= watchXtalTick;
			rtcSecond_q <= watchXtalTick && (watchCnt_q == `CSAD_WATCH_LAST);
			if (watchXtalTick) begin
				watchCnt_q <= watchCnt_q + 15'h0001;
			end
		end
	end

	// USB domain takes the interconnect 48 MHz clock or the doubled source.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			usbTick_q <= 1'b0;
		end else begin
			usbTick_q <= usbSrcSel ? dsiTick : dblTick_q;
		end
	end

	csad_lowpower u_lowpower (
		.clock       (clock),
		.rstn        (rstn),
		.hibernate   (hibernate),
		.debugHalt   (debugHalt),
		.ctcClear    (ctcClear),
		.ctcTap      (ctcTap),
		.ftcIrqEn    (ftcIrqEn),
		.ftcTerminal (ftcTerminal),
		.lpfTick     (lpfTickInt),
		.slowTick    (slowTick),
		.thirdTick   (thirdTick),
		.ctcCount    (ctcCount),
		.ctcEvent    (ctcEvent),
		.ftcCount    (ftcCount),
		.ftcIrq      (ftcIrq)
	);

	csad_div_if dvIf [`CSAD_NDIV] ();

	// Divider 0 makes the bus clock, divider 1 the CPU clock from it.
	assign dvIf[0].srcTick  = {8{masterTick_q}};
	assign dvIf[0].srcSel   = 3'h0;
	assign dvIf[0].divVal   = busDiv;
	assign dvIf[0].skew     = 4'h0;
	assign dvIf[0].resyncEn = 1'b1;
	assign dvIf[1].srcTick  = {8{dvIf[0].tickOut}};
	assign dvIf[1].srcSel   = 3'h0;
	assign dvIf[1].divVal   = cpuDiv;
	assign dvIf[1].skew     = 4'h0;
	assign dvIf[1].resyncEn = 1'b1;

	genvar gi;
	generate
		for (gi = 0; gi < `CSAD_NDIV; gi++) begin : g_div
			assign dvIf[gi].masterTick = masterTick_q;
			csad_divider u_div (
				.clock (clock),
				.rstn  (rstn),
				.dv    (dvIf[gi])
			);
		end
		// Digital dividers: seven sources plus their own interconnect clock.
		for (gi = 0; gi < 8; gi++) begin : g_dig
			assign dvIf[gi + `CSAD_DIG_BASE].srcTick  = {dsiDigTick[gi], srcVec};
			assign dvIf[gi + `CSAD_DIG_BASE].srcSel   = digSel[gi];
			assign dvIf[gi + `CSAD_DIG_BASE].divVal   = digDiv[gi];
			assign dvIf[gi + `CSAD_DIG_BASE].skew     = 4'h0;
			assign dvIf[gi + `CSAD_DIG_BASE].resyncEn = digResync[gi];
			assign digClk[gi] = dvIf[gi + `CSAD_DIG_BASE].clkOut;
		end
		// Analog dividers: always resynchronised, each with its own skew delay.
		for (gi = 0; gi < 4; gi++) begin : g_ana
			assign dvIf[gi + `CSAD_ANA_BASE].srcTick  = {dsiTick, srcVec};
			assign dvIf[gi + `CSAD_ANA_BASE].srcSel   = anaSel[gi];
			assign dvIf[gi + `CSAD_ANA_BASE].divVal   = anaDiv[gi];
			assign dvIf[gi + `CSAD_ANA_BASE].skew     = anaSkew[gi];
			assign dvIf[gi + `CSAD_ANA_BASE].resyncEn = 1'b1;
			assign anaClk[gi] = dvIf[gi + `CSAD_ANA_BASE].clkOut;
		end
	endgenerate

	// Every output but pllLocked is taken from a flip-flop; pllLocked is decoded from pllState_q.
	assign mainOscFreqSel = mainOscFreqSel_q;
	assign pllLocked      = (pllState_q == csad_pkg::PLL_LOCKED);
	assign pllLockPulse   = pllLockPulse_q;
	assign pllTick        = pllTick_q;
	assign dblTick        = dblTick_q;
	assign lpfTick        = lpfTickInt;
	assign sleepTick      = sleepTick_q;
	assign rtcSecond      = rtcSecond_q;
	assign masterTick     = masterTick_q;
	assign busClk         = dvIf[0].clkOut;
	assign cpuClk         = dvIf[1].clkOut;
	assign usbTick        = usbTick_q;
endmodule : csad_top

// ==== verification/csad_props.sv ====
// Concurrent checks on the ports of the clock control block.
`timescale 1ns/1ns
module csad_props #(
	parameter int unsigned PLL_LOCK_CYC = 5000
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic [2:0]  mainOscCode,
	input wire logic        fastXtalTick,
	input wire logic        watchXtalTick,
	input wire logic [2:0]  masterSel,
	input wire logic        pllEnable,
	input wire logic        hibernate,
	input wire logic        debugHalt,
	input wire logic        ctcClear,
	input wire logic        ftcIrqEn,
	input wire logic [2:0]  mainOscFreqSel,
	input wire logic        pllLocked,
	input wire logic        pllLockPulse,
	input wire logic        pllTick,
	input wire logic        lpfTick,
	input wire logic        slowTick,
	input wire logic        thirdTick,
	input wire logic [12:0] ctcCount,
	input wire logic [4:0]  ftcCount,
	input wire logic        ftcIrq,
	input wire logic        sleepTick,
	input wire logic        masterTick
);
	logic [1:0] upQ;
	logic       live;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Counts edges after reset so that the first edges out of reset are not judged.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			upQ <= 2'h0;
		end else if (upQ != 2'h3) begin
			upQ <= upQ + 2'h1;
		end
	end
	// Every check but a_pllOff may fire only once the block has left reset for a few edges.
	assign live = (upQ == 2'h3);
	property p_freq; live |=> mainOscFreqSel ==
		(($past(mainOscCode) <= 3'h5) ? $past(mainOscCode) : $past(mainOscFreqSel)); endproperty
	a_freq: assert property (p_freq) else $error("range select wrong");
	property p_master; live && masterSel == 3'h1 |=> masterTick == $past(fastXtalTick); endproperty
	a_master: assert property (p_master) else $error("master tick wrong");
	property p_sleep; live |=> sleepTick == $past(watchXtalTick); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep tick wrong");
	property p_lock; live |-> pllLockPulse == $rose(pllLocked); endproperty
	a_lock: assert property (p_lock) else $error("lock pulse wrong");
	property p_pllOff; (!pllEnable) [*4] |-> !pllTick && !pllLocked; endproperty
	a_pllOff: assert property (p_pllOff) else $error("pll active while off");
	property p_ctcStep; live && $changed(ctcCount) && !$past(ctcClear) |->
		ctcCount == $past(ctcCount) + 13'h1; endproperty
	a_ctcStep: assert property (p_ctcStep) else $error("central count step wrong");
	property p_ctcStop; (live && (hibernate || debugHalt) && !ctcClear) [*2] |-> $stable(ctcCount); endproperty
	a_ctcStop: assert property (p_ctcStop) else $error("central count moved while stopped");
	property p_ctcClr; live && ctcClear |=> ctcCount == 13'h0; endproperty
	a_ctcClr: assert property (p_ctcClr) else $error("central count not cleared");
	property p_ftcIrq; live && ftcIrq |-> ftcCount == 5'h0 && $past(ftcIrqEn); endproperty
	a_ftcIrq: assert property (p_ftcIrq) else $error("fast tick interrupt wrong");
	property p_third; live && (thirdTick || slowTick) |-> $past(lpfTick); endproperty
	a_third: assert property (p_third) else $error("derived slow tick off the fast tick");
endmodule : csad_props

bind csad_top csad_props #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) u_props (
	.clock, .rstn, .mainOscCode, .fastXtalTick, .watchXtalTick, .masterSel, .pllEnable, .hibernate,
	.debugHalt, .ctcClear, .ftcIrqEn, .mainOscFreqSel, .pllLocked, .pllLockPulse, .pllTick, .lpfTick,
	.slowTick, .thirdTick, .ctcCount, .ftcCount, .ftcIrq, .sleepTick, .masterTick
);

// ==== verification/csad_partner.sv ====
// Oscillator and interconnect tick sources that feed the clock control block.
`timescale 1ns/1ns
module csad_partner #(
	parameter int MAIN_P  = 10,
	parameter int XTAL_P  = 2,
	parameter int WATCH_P = 7,
	parameter int DSI_P   = 3
) (
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       run,
	input wire logic [3:0] manual,
	output logic           mainOscTick,
	output logic           fastXtalTick,
	output logic           watchXtalTick,
	output logic           dsiTick
);
	int cyc = 0;
	// Free cycle count, moved on the falling edge so ticks never race the sampling edge.
	always @(negedge clock) begin
		cyc <= rstn ? cyc + 1 : 0;
	end
	// Each source pulses for one cycle at its own period, or when the bench asks for one.
	assign mainOscTick = manual[0] | (run && cyc % MAIN_P == 0);
	assign fastXtalTick = manual[1] | (run && cyc % XTAL_P == 0);
	assign watchXtalTick = manual[2] | (run && cyc % WATCH_P == 0);
	assign dsiTick = manual[3] | (run && cyc % DSI_P == 0);
endmodule : csad_partner

// ==== verification/testbench.sv ====
// Self-checking bench for the clock control block.
`timescale 1ns/1ns
module testbench;
	localparam int unsigned LOCK = 200;
	typedef struct packed {
		logic [2:0] code;
		logic [2:0] freq;
		logic [2:0] sel;
		logic [3:0] mask;
		logic       tick;
	} csad_row_s;
	// Range code, expected range, master source, pulsed sources, expected master tick.
	csad_row_s rows [0:5] = '{'{3'h0, 3'h0, 3'h0, 4'h1, 1'h1}, '{3'h3, 3'h3, 3'h1, 4'h2, 1'h1},
		'{3'h5, 3'h5, 3'h3, 4'h4, 1'h1}, '{3'h6, 3'h5, 3'h5, 4'h8, 1'h1}, '{3'h7, 3'h5, 3'h7, 4'h1, 1'h1},
		'{3'h1, 3'h1, 3'h1, 4'h1, 1'h0}};
	localparam int PER [0:7] = '{600, 600, 0, 10, 4, 9, 12, 12};
	int          errors = 0, compares = 0;
	logic        clock = 1'h0, rstn = 1'h0, run = 1'h0, pllEnable = 1'h0, usbSrcSel = 1'h1;
	logic        hibernate = 1'h0, debugHalt = 1'h0, ctcClear = 1'h0, ftcIrqEn = 1'h1;
	logic [3:0]  manual = 4'h0, ctcTap = 4'h0;
	logic [2:0]  mainOscCode = 3'h0, masterSel = 3'h0;
	logic [1:0]  dblSrcSel = 2'h0, pllSrcSel = 2'h0;
	logic [5:0]  pllInDiv = 6'h01, pllFbDiv = 6'h03;
	logic [4:0]  ftcTerminal = 5'h02;
	logic [15:0] busDiv = 16'h0002, cpuDiv = 16'h0003;
	logic [7:0]  digResync = 8'h01;
	logic        mainOscTick, fastXtalTick, watchXtalTick, dsiTick;
	logic [2:0]  mainOscFreqSel;
	logic        pllLocked, pllLockPulse, pllTick, dblTick, slowTick, thirdTick, ftcIrq, ctcEvent;
	logic        sleepTick, masterTick, busClk, cpuClk, usbTick;
	logic [12:0] ctcCount;
	logic [7:0]  digClk;
	logic [3:0]  anaClk;
	logic [11:0] pr, prQ;
	csad_partner src (.clock, .rstn, .run, .manual, .mainOscTick, .fastXtalTick, .watchXtalTick, .dsiTick);
	csad_top #(.PLL_LOCK_CYC(LOCK)) uut (
		.clock, .rstn, .mainOscTick, .mainOscCode, .fastXtalTick, .watchXtalTick, .dsiTick,
		.dsiDigTick({8{dsiTick}}), .dblSrcSel, .pllEnable, .pllSrcSel, .pllInDiv, .pllFbDiv, .usbSrcSel,
		.hibernate, .debugHalt, .ctcClear, .ctcTap, .ftcIrqEn, .ftcTerminal, .masterSel, .busDiv, .cpuDiv,
		.digSel(24'hE00001), .digDiv({16'h0003, 96'h0, 16'h0005}), .digResync, .anaSel(12'h005),
		.anaDiv(64'h4), .anaSkew(16'h0002), .mainOscFreqSel, .pllLocked, .pllLockPulse, .pllTick, .dblTick,
		.lpfTick(), .slowTick, .thirdTick, .ctcCount, .ctcEvent, .ftcCount(), .ftcIrq, .sleepTick, .rtcSecond(),
		.masterTick, .busClk, .cpuClk, .digClk, .anaClk, .usbTick
	);
	// Signals watched by the counting and period tasks, one bit each.
	assign pr = {pllLockPulse, usbTick, dblTick, pllTick, cpuClk, anaClk[0], digClk[7], busClk, digClk[0],
		slowTick, thirdTick, ftcIrq};
	// Previous sample of the watched signals, for edge detection.
	always @(negedge clock) prQ <= pr;
	// The system clock.
	initial forever #25 clock = ~clock;
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// Counts the cycles in which a watched signal is high over a fixed span.
	task automatic cnt(input string s, input int i, input int c, input logic [15:0] e);
		int n;
		n = 0;
		repeat (c) begin
			@(negedge clock);
			n += int'(pr[i]);
		end
		chk(s, e, 16'(n));
	endtask : cnt
	// Measures the cycles from one rising edge of a watched signal to the next.
	task automatic per(input string s, input int i, input logic [15:0] e);
		int n;
		n = -1;
		for (int t = 0; t < 45000; t++) begin
			@(negedge clock);
			if (n >= 0) n++;
			if (pr[i] === 1'h1 && prQ[i] === 1'h0) begin
				if (n > 0) break;
				n = 0;
			end
		end
		chk(s, e, 16'(n));
	endtask : per
	task results;
		if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// Cuts a hung run short.
	initial begin
		repeat (90000) @(posedge clock);
		errors++;
		results();
	end
	// Main sequence: table of selections first, then the timed cases.
	initial begin
		int n;
		repeat (10) @(negedge clock);
		chk("reset", 16'h0, {mainOscFreqSel, ctcCount});
		rstn = 1'h1;
		repeat (3) @(negedge clock);
		foreach (rows[k]) begin
			mainOscCode = rows[k].code;
			masterSel = rows[k].sel;
			manual = rows[k].mask;
			@(negedge clock);
			manual = 4'h0;
			chk("freq", 16'(rows[k].freq), 16'(mainOscFreqSel));
			chk("master", 16'(rows[k].tick), 16'(masterTick));
			chk("sleep", 16'(rows[k].mask[2]), 16'(sleepTick));
			chk("usb", 16'(rows[k].mask[3]), 16'(usbTick));
			@(negedge clock);
		end
		run = 1'h1;
		repeat (40) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			if (i != 2) per("period", i, 16'(PER[i]));
		end
		ftcIrqEn = 1'h0;
		cnt("ftcOff", 0, 700, 16'h0);
		pllEnable = 1'h1;
		repeat (40) @(negedge clock);
		cnt("pllLocking", 8, 100, 16'h000F);
		n = 140;
		while (pllLocked !== 1'h1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		chk("lockTime", 16'(LOCK + 1), 16'(n));
		chk("lockPulse", 16'h1, 16'(pllLockPulse));
		pllEnable = 1'h0;
		repeat (4) @(negedge clock);
		cnt("pllOff", 8, 50, 16'h0);
		chk("unlock", 16'h0, 16'(pllLocked));
		usbSrcSel = 1'h0;
		repeat (4) @(negedge clock);
		cnt("doubler", 9, 100, 16'h0014);
		cnt("usbDbl", 10, 100, 16'h0014);
		per("slow", 2, 16'h4E20);
		@(negedge clock);
		chk("ctcEvent", 16'h1, 16'(ctcEvent));
		@(negedge clock);
		chk("ctc", 16'h2, 16'(ctcCount));
		hibernate = 1'h1;
		cnt("slowHeld", 2, 20000, 16'h1);
		chk("ctcHeld", 16'h2, 16'(ctcCount));
		hibernate = 1'h0;
		debugHalt = 1'h1;
		ctcClear = 1'h1;
		@(negedge clock);
		ctcClear = 1'h0;
		@(negedge clock);
		chk("ctcClear", 16'h0, 16'(ctcCount));
		debugHalt = 1'h0;
		results();
	end
endmodule : testbench
